//--- rtl/scp_pkg.sv
// Shared constants and types for the serial configuration port.
// Assumes one clk_i domain with a register file and one serial-clock domain at the pins.
package scp_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam int RW_BIT = 7;
  localparam int LEN_BIT = 6;
  localparam int BIT_IDX_W = 3;
  localparam int BYTE_SEL_BIT = 3;
  localparam logic [CNT_W-1:0] CNT_INSTR_LAST = 5'h07;
  localparam logic [CNT_W-1:0] CNT_INSTR_DONE = 5'h08;
  localparam logic [CNT_W-1:0] CNT_ONE_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] CNT_ONE_DONE = 5'h10;
  localparam logic [CNT_W-1:0] CNT_TWO_LAST = 5'h17;
  localparam logic [CNT_W-1:0] CNT_TWO_DONE = 5'h18;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 6'h01;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h00;

  typedef enum logic [2:0] {
    PH_INSTR = 3'b001,
    PH_WRITE = 3'b010,
    PH_READ = 3'b100
  } scp_phase_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIRST = 3'b010,
    ST_SECOND = 3'b100
  } scp_step_e;

  // One decoded access handed from the serial clock to the system clock.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] addr2;
    logic two;
    logic [DATA_W-1:0] data0;
    logic [DATA_W-1:0] data1;
  } scp_xfer_s;

  localparam scp_xfer_s XFER_RESET = '{ADDR_RESET, ADDR_RESET, 1'b0, DATA_RESET, DATA_RESET};
endpackage : scp_pkg

//--- rtl/scp_serial_port.sv
// Serial configuration port: pin-side shifter on the serial clock, register-side port on clk_i.
// Assumes a register file on clk_i answering reg_rd_data_i combinationally from reg_rd_addr_o,
// and a serial clock much slower than clk_i (link at 160 ns, clk_i at 5 ns).
`timescale 1ns/10ps
`default_nettype none

module scp_serial_port (
  input wire logic clk_i, // System clock, 200 MHz.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic sclk_i, // Serial clock from the controller.
  input wire logic serial_enable_n_i, // Frame enable, active low.
  input wire logic sdio_i, // Data pin, input level.
  output logic sdio_o, // Data pin, output level.
  output logic sdio_oe_o, // Data pin output enable.
  output logic serial_data_out_o, // Separate output pin level.
  output logic serial_data_out_oe_o, // Separate output pin enable.
  input wire logic three_wire_select_i, // Shared data pin for reads when high.
  input wire logic lsb_first_i, // LSB-first bit order when high.
  output logic reg_wr_en_o, // Register write strobe.
  output logic [scp_pkg::ADDR_W-1:0] reg_wr_addr_o, // Register write address.
  output logic [scp_pkg::DATA_W-1:0] reg_wr_data_o, // Register write data.
  output logic [scp_pkg::ADDR_W-1:0] reg_rd_addr_o, // Register read address.
  input wire logic [scp_pkg::DATA_W-1:0] reg_rd_data_i // Register read data.
);

  function automatic logic [scp_pkg::DATA_W-1:0] shift_in(
    input logic [scp_pkg::DATA_W-1:0] sh, input logic b, input logic lsb);
    shift_in = lsb ? {b, sh[scp_pkg::DATA_W-1:1]} : {sh[scp_pkg::DATA_W-2:0], b};
  endfunction : shift_in

  function automatic logic [scp_pkg::ADDR_W-1:0] second_addr(
    input logic [scp_pkg::ADDR_W-1:0] a, input logic lsb);
    second_addr = lsb ? a + scp_pkg::ADDR_STEP : a - scp_pkg::ADDR_STEP;
  endfunction : second_addr

  // Frame state and output flops are reset whenever the frame is not active.
  logic frame_rst_n;
  assign frame_rst_n = rst_n_i & ~serial_enable_n_i;

  // Configuration levels cross into the serial clock through two flip-flops.
  logic [1:0] lsb_sync;
  logic [1:0] wire3_sync;
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lsb_sync <= 2'h0;
      wire3_sync <= 2'h0;
    end else begin
      lsb_sync <= {lsb_sync[0], lsb_first_i};
      wire3_sync <= {wire3_sync[0], three_wire_select_i};
    end
  end
  logic lsb_s;
  logic wire3_s;
  assign lsb_s = lsb_sync[1];
  assign wire3_s = wire3_sync[1];

  // Frame state on the rising serial clock edge.
  logic [scp_pkg::CNT_W-1:0] cnt;
  logic [scp_pkg::CNT_W-1:0] next_cnt;
  scp_pkg::scp_phase_e phase;
  scp_pkg::scp_phase_e next_phase;
  logic [scp_pkg::DATA_W-1:0] shreg;
  logic [scp_pkg::DATA_W-1:0] next_shreg;
  logic [scp_pkg::ADDR_W-1:0] addr;
  logic [scp_pkg::ADDR_W-1:0] next_addr;
  logic two;
  logic next_two;
  logic [scp_pkg::DATA_W-1:0] data0;
  logic [scp_pkg::DATA_W-1:0] next_data0;
  // Crossing records survive the end of a frame, so only the system reset clears them.
  scp_pkg::scp_xfer_s wr_rec;
  scp_pkg::scp_xfer_s next_wr_rec;
  scp_pkg::scp_xfer_s rd_rec;
  scp_pkg::scp_xfer_s next_rd_rec;
  logic wr_tgl;
  logic next_wr_tgl;
  logic rd_tgl;
  logic next_rd_tgl;

  always_comb begin
    logic [scp_pkg::DATA_W-1:0] nsh;
    nsh = shift_in(shreg, sdio_i, lsb_s);
    next_shreg = nsh;
    next_cnt = (cnt == scp_pkg::CNT_MAX) ? cnt : cnt + 5'h01;
    next_phase = phase;
    next_addr = addr;
    next_two = two;
    next_data0 = data0;
    next_wr_rec = wr_rec;
    next_rd_rec = rd_rec;
    next_wr_tgl = wr_tgl;
    next_rd_tgl = rd_tgl;
    case (phase)
      scp_pkg::PH_INSTR: begin
        if (cnt == scp_pkg::CNT_INSTR_LAST) begin
          next_addr = nsh[scp_pkg::ADDR_W-1:0];
          next_two = nsh[scp_pkg::LEN_BIT];
          if (nsh[scp_pkg::RW_BIT]) begin
            next_phase = scp_pkg::PH_READ;
            next_rd_rec = '{nsh[scp_pkg::ADDR_W-1:0],
                            second_addr(nsh[scp_pkg::ADDR_W-1:0], lsb_s),
                            nsh[scp_pkg::LEN_BIT], scp_pkg::DATA_RESET, scp_pkg::DATA_RESET};
            next_rd_tgl = ~rd_tgl;
          end else begin
            next_phase = scp_pkg::PH_WRITE;
          end
        end
      end
      scp_pkg::PH_WRITE: begin
        if (cnt == scp_pkg::CNT_ONE_LAST) begin
          next_data0 = nsh;
          if (!two) begin
            next_wr_rec = '{addr, second_addr(addr, lsb_s), 1'b0, nsh, nsh};
            next_wr_tgl = ~wr_tgl;
          end
        end else if (cnt == scp_pkg::CNT_TWO_LAST && two) begin
          next_wr_rec = '{addr, second_addr(addr, lsb_s), 1'b1, data0, nsh};
          next_wr_tgl = ~wr_tgl;
        end
      end
      scp_pkg::PH_READ: begin
        next_phase = scp_pkg::PH_READ;
      end
      default: begin
        next_phase = scp_pkg::PH_INSTR;
      end
    endcase
  end

  // A write frame that ends early never reaches its commit count, so no write is handed over.
  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt <= '0;
      phase <= scp_pkg::PH_INSTR;
      shreg <= scp_pkg::DATA_RESET;
      addr <= scp_pkg::ADDR_RESET;
      two <= 1'b0;
      data0 <= scp_pkg::DATA_RESET;
    end else begin
      cnt <= next_cnt;
      phase <= next_phase;
      shreg <= next_shreg;
      addr <= next_addr;
      two <= next_two;
      data0 <= next_data0;
    end
  end

  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_rec <= scp_pkg::XFER_RESET;
      rd_rec <= scp_pkg::XFER_RESET;
      wr_tgl <= 1'b0;
      rd_tgl <= 1'b0;
    end else begin
      wr_rec <= next_wr_rec;
      rd_rec <= next_rd_rec;
      wr_tgl <= next_wr_tgl;
      rd_tgl <= next_rd_tgl;
    end
  end

  // Read bytes fetched on clk_i. They settle tens of ns after the instruction edge, long
  // before the next falling serial edge, and stay put until the next read request.
  logic [scp_pkg::DATA_W-1:0] hold0;
  logic [scp_pkg::DATA_W-1:0] hold1;

  // Output side on the falling serial clock edge.
  logic out_bit;
  logic next_out_bit;
  logic out_drive;
  logic next_out_drive;
  logic out_wire3;
  logic next_out_wire3;

  always_comb begin
    logic [scp_pkg::CNT_W-1:0] idx;
    logic [scp_pkg::DATA_W-1:0] cur;
    logic [scp_pkg::BIT_IDX_W-1:0] j;
    idx = cnt - scp_pkg::CNT_INSTR_DONE;
    cur = idx[scp_pkg::BYTE_SEL_BIT] ? hold1 : hold0;
    j = idx[scp_pkg::BIT_IDX_W-1:0];
    next_out_bit = lsb_s ? cur[j] : cur[~j];
    next_out_drive = (phase == scp_pkg::PH_READ) &&
                     (cnt < (two ? scp_pkg::CNT_TWO_DONE : scp_pkg::CNT_ONE_DONE));
    next_out_wire3 = wire3_s;
  end

  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_bit <= 1'b0;
      out_drive <= 1'b0;
      out_wire3 <= 1'b0;
    end else begin
      out_bit <= next_out_bit;
      out_drive <= next_out_drive;
      out_wire3 <= next_out_wire3;
    end
  end

  assign sdio_o = out_bit;
  assign serial_data_out_o = out_bit;
  assign sdio_oe_o = out_drive & out_wire3;
  assign serial_data_out_oe_o = out_drive & ~out_wire3;

  // System-clock side: toggle synchronisers, then write and read sequencers.
  logic [2:0] wr_sync;
  logic [2:0] rd_sync;
  logic wr_evt;
  logic rd_evt;
  assign wr_evt = wr_sync[2] ^ wr_sync[1];
  assign rd_evt = rd_sync[2] ^ rd_sync[1];

  scp_pkg::scp_step_e wstep;
  scp_pkg::scp_step_e next_wstep;
  scp_pkg::scp_step_e rstep;
  scp_pkg::scp_step_e next_rstep;
  logic next_wr_en;
  logic [scp_pkg::ADDR_W-1:0] next_wr_addr;
  logic [scp_pkg::DATA_W-1:0] next_wr_data;
  logic [scp_pkg::ADDR_W-1:0] next_rd_addr;
  logic [scp_pkg::DATA_W-1:0] next_hold0;
  logic [scp_pkg::DATA_W-1:0] next_hold1;

  always_comb begin
    next_wstep = scp_pkg::ST_IDLE;
    next_wr_en = 1'b0;
    next_wr_addr = reg_wr_addr_o;
    next_wr_data = reg_wr_data_o;
    case (wstep)
      scp_pkg::ST_IDLE: begin
        if (wr_evt) begin
          next_wr_en = 1'b1;
          next_wr_addr = wr_rec.addr;
          next_wr_data = wr_rec.data0;
          next_wstep = wr_rec.two ? scp_pkg::ST_FIRST : scp_pkg::ST_IDLE;
        end
      end
      scp_pkg::ST_FIRST: begin
        next_wr_en = 1'b1;
        next_wr_addr = wr_rec.addr2;
        next_wr_data = wr_rec.data1;
      end
      default: begin
        next_wstep = scp_pkg::ST_IDLE;
      end
    endcase
  end

  always_comb begin
    next_rstep = scp_pkg::ST_IDLE;
    next_rd_addr = reg_rd_addr_o;
    next_hold0 = hold0;
    next_hold1 = hold1;
    case (rstep)
      scp_pkg::ST_IDLE: begin
        if (rd_evt) begin
          next_rd_addr = rd_rec.addr;
          next_rstep = scp_pkg::ST_FIRST;
        end
      end
      scp_pkg::ST_FIRST: begin
        next_hold0 = reg_rd_data_i;
        next_rd_addr = rd_rec.addr2;
        next_rstep = scp_pkg::ST_SECOND;
      end
      scp_pkg::ST_SECOND: begin
        next_hold1 = reg_rd_data_i;
      end
      default: begin
        next_rstep = scp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_sync <= 3'h0;
      rd_sync <= 3'h0;
      wstep <= scp_pkg::ST_IDLE;
      rstep <= scp_pkg::ST_IDLE;
      reg_wr_en_o <= 1'b0;
      reg_wr_addr_o <= scp_pkg::ADDR_RESET;
      reg_wr_data_o <= scp_pkg::DATA_RESET;
      reg_rd_addr_o <= scp_pkg::ADDR_RESET;
      hold0 <= scp_pkg::DATA_RESET;
      hold1 <= scp_pkg::DATA_RESET;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_tgl};
      rd_sync <= {rd_sync[1:0], rd_tgl};
      wstep <= next_wstep;
      rstep <= next_rstep;
      reg_wr_en_o <= next_wr_en;
      reg_wr_addr_o <= next_wr_addr;
      reg_wr_data_o <= next_wr_data;
      reg_rd_addr_o <= next_rd_addr;
      hold0 <= next_hold0;
      hold1 <= next_hold1;
    end
  end

endmodule : scp_serial_port

`default_nettype wire

//--- bench/scp_serial_port_checker.sv
// Concurrent checks on the serial configuration port, bound to its top module.
// Assumes the serial clock idles low and config inputs only change between frames.
`timescale 1ns/10ps
`default_nettype none
module scp_serial_port_checker (
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic sclk_i, // Serial clock.
  input wire logic serial_enable_n_i, // Frame enable, active low.
  input wire logic sdio_oe_o, // Data pin enable.
  input wire logic serial_data_out_o, // Output pin level.
  input wire logic serial_data_out_oe_o, // Output pin enable.
  input wire logic three_wire_select_i, // Three-wire mode.
  input wire logic lsb_first_i, // LSB-first order.
  input wire logic reg_wr_en_o, // Write strobe.
  input wire logic [scp_pkg::ADDR_W-1:0] reg_wr_addr_o, // Write address.
  input wire logic [scp_pkg::DATA_W-1:0] reg_wr_data_o // Write data.
);
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  wire logic oe = sdio_oe_o | serial_data_out_oe_o;

  // Rising serial edges seen in the current frame, saturating so long frames cannot wrap.
  always_comb next_cnt = (cnt == 5'h1f) ? cnt : cnt + 5'h01;
  always_ff @(posedge sclk_i or posedge serial_enable_n_i or negedge rst_n_i) begin
    if (!rst_n_i || serial_enable_n_i) cnt <= 5'h00;
    else cnt <= next_cnt;
  end

  hiz_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    serial_enable_n_i |-> !oe) else $error("pin driven while enable high");
  out_float_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    serial_data_out_oe_o |-> !three_wire_select_i) else $error("output pin in 3-wire");
  sdio_mode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sdio_oe_o |-> three_wire_select_i) else $error("data pin driven in 4-wire");
  oe_fall_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(oe) |-> !sclk_i) else $error("drive began off falling edge");
  bit_fall_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !serial_enable_n_i && $changed(serial_data_out_o) |-> !sclk_i)
    else $error("output bit moved off falling edge");
  instr_quiet_a: assert property (@(posedge sclk_i)
    disable iff (!rst_n_i || serial_enable_n_i) oe |-> cnt >= 5'h08)
    else $error("drive during instruction");
  wr_in_frame_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(reg_wr_en_o) |-> sclk_i && !serial_enable_n_i) else $error("stray write");
  wr_burst_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_wr_en_o ##1 reg_wr_en_o |=> !reg_wr_en_o) else $error("write burst too long");
  wr_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !reg_wr_en_o |-> $stable(reg_wr_addr_o) && $stable(reg_wr_data_o))
    else $error("write port moved without strobe");
  addr_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_wr_en_o && $past(reg_wr_en_o) |-> reg_wr_addr_o == (lsb_first_i ?
    $past(reg_wr_addr_o) + 6'h01 : $past(reg_wr_addr_o) - 6'h01))
    else $error("second address wrong");
endmodule : scp_serial_port_checker

bind scp_serial_port scp_serial_port_checker chk (.*);
`default_nettype wire

//--- bench/scp_ctrl_model.sv
// Behavioural system controller that frames transfers on the serial pins.
// Assumes the bench resolves the shared data pin from both enables.
`timescale 1ns/10ps
`default_nettype none
module scp_ctrl_model (
  output logic sclk_o, // Serial clock, low outside frames apart from two idle pulses before each one.
  output logic en_n_o, // Frame enable, active low.
  output logic sdio_o, // Data level from the controller.
  output logic sdio_oe_o, // High while the controller drives.
  input wire logic sdio_i, // Resolved data pin.
  input wire logic out_pin_i, // Separate output pin.
  input wire logic out_pin_oe_i // Separate output pin enable.
);
  initial begin
    sclk_o = 1'b0;
    en_n_o = 1'b1;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b0;
  end

  // Two idle pulses let the config synchronisers settle; the enable is high, so they are ignored.
  task automatic xfer(input logic [23:0] bits, input int n, input logic lsb,
                      output logic [7:0] rd);
    int k;
    rd = 8'h00;
    #61.3;
    repeat (2) begin
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    en_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      k = lsb ? i % 8 : 7 - i % 8;
      sdio_oe_o = !(bits[23] && i >= 8);
      sdio_o = sdio_oe_o ? bits[16 - 8 * (i / 8) + k] : !sdio_o;
      #80 sclk_o = 1'b1;
      if (i >= 8) rd[k] = out_pin_oe_i ? out_pin_i : sdio_i;
      #80 sclk_o = 1'b0;
    end
    #40 en_n_o = 1'b1;
    sdio_oe_o = 1'b0;
  endtask : xfer
endmodule : scp_ctrl_model
`default_nettype wire

//--- bench/scp_serial_port_test.sv
// Self-checking bench: controller model on the pins, register file on the system clock.
// Assumes each write commits before the model finishes its frame.
`timescale 1ns/10ps
`default_nettype none
module scp_serial_port_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic three_wire = 1'b0;
  logic lsb = 1'b0;
  logic sclk, en_n, c_sdio, c_oe, d_sdio, d_oe, ser_out, ser_out_oe, wr_en, pin;
  logic [5:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd;
  logic [7:0] regs [64];
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;
  assign pin = d_oe ? d_sdio : (c_oe ? c_sdio : !c_sdio);

  scp_serial_port uut (.clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .serial_enable_n_i(en_n),
    .sdio_i(pin), .sdio_o(d_sdio), .sdio_oe_o(d_oe), .serial_data_out_o(ser_out),
    .serial_data_out_oe_o(ser_out_oe), .three_wire_select_i(three_wire), .lsb_first_i(lsb),
    .reg_wr_en_o(wr_en), .reg_wr_addr_o(wr_addr), .reg_wr_data_o(wr_data),
    .reg_rd_addr_o(rd_addr), .reg_rd_data_i(regs[rd_addr]));
  scp_ctrl_model ctrl (.sclk_o(sclk), .en_n_o(en_n), .sdio_o(c_sdio), .sdio_oe_o(c_oe),
    .sdio_i(pin), .out_pin_i(ser_out), .out_pin_oe_i(ser_out_oe));

  task automatic stop_test;
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wr_en) regs[wr_addr] <= wr_data;
    if (cycles == 30000) begin
      num_errors++;
      stop_test;
    end
  end

  task automatic write_one;
    ctrl.xfer({8'h05, 8'ha5, 8'h00}, 16, 1'b0, rd);
    check(regs[6'h05], 8'ha5);
    check(regs[6'h04], 8'h84);
  endtask : write_one

  task automatic write_two;
    ctrl.xfer({8'h50, 8'h3c, 8'hc3}, 24, 1'b0, rd);
    check(regs[6'h10], 8'h3c);
    check(regs[6'h0f], 8'hc3);
    @(posedge clk) #1 lsb = 1'b1;
    ctrl.xfer({8'h60, 8'h5a, 8'ha6}, 24, 1'b1, rd);
    check(regs[6'h20], 8'h5a);
    check(regs[6'h21], 8'ha6);
    @(posedge clk) #1 lsb = 1'b0;
  endtask : write_two

  task automatic write_abort;
    ctrl.xfer({8'h07, 8'h11, 8'h00}, 15, 1'b0, rd);
    check(regs[6'h07], 8'h87);
    ctrl.xfer({8'h48, 8'h22, 8'h33}, 23, 1'b0, rd);
    check(regs[6'h08], 8'h88);
    check(regs[6'h07], 8'h87);
  endtask : write_abort

  task automatic read_all;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) #1 three_wire = m[1];
      lsb = m[0];
      ctrl.xfer({2'b10, 6'(6'h30 + m), 16'h0000}, 16, m[0], rd);
      check(rd, {2'b10, 6'(6'h30 + m)});
      check({7'h00, d_oe | ser_out_oe}, 8'h00);
    end
    // The loop leaves three-wire LSB-first set, so the second byte comes from the next address up.
    ctrl.xfer({2'b11, 6'h12, 16'h0000}, 24, 1'b1, rd);
    check(rd, 8'h93);
    check({7'h00, d_oe | ser_out_oe}, 8'h00);
  endtask : read_all

  initial begin
    for (int i = 0; i < 64; i++) regs[i] = {2'b10, 6'(i)};
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    write_one;
    write_two;
    write_abort;
    read_all;
    stop_test;
  end
endmodule : scp_serial_port_test
`default_nettype wire
